// [verilog/rpac_pkg.sv]
// Constants and register map of the reset, power and scratch memory control.
package rpac_pkg;

    // ------------------------------------------------------------------
    // Register addresses in the special register space
    // ------------------------------------------------------------------
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
    localparam logic [7:0] CHIP_CTRL_ADDR = 8'hBF;
    localparam logic [7:0] CHIP_UNLOCK_ADDR = 8'hF6;

    // ------------------------------------------------------------------
    // Unlock sequence values
    // ------------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h87;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h59;
    localparam logic [7:0] UNLOCK_RELOCK = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IDLE_REQUEST_BIT = 0;
    localparam int POWERDOWN_REQUEST_BIT = 1;
    localparam int PWR_KEEP_BIT = 4;
    localparam int AUX_ENABLE_BIT = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PWR_CTRL_POR = 8'h30;
    localparam logic [7:0] SFR_CLEAR_VAL = 8'h00;
    localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
    localparam logic [7:0] STACK_POINTER_RST = 8'h07;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam logic [3:0] OSC_LAST = 4'hB;
    localparam logic [3:0] S5P2_CNT = 4'h9;
    localparam logic [1:0] RST_MIN_MC = 2'h2;
    localparam int CLK_NS = 40;
    localparam int GLITCH_NS = 100;
    localparam logic [1:0] GLITCH_CYC =
        2'((GLITCH_NS + CLK_NS - 1) / CLK_NS);

    // ------------------------------------------------------------------
    // Unlock state machine
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        UL_LOCKED = 2'b00,
        UL_KEY1 = 2'b01,
        UL_OPEN = 2'b10
    } rpac_unl_t;

endpackage

// [verilog/rpac_ctrl.sv]
// Reset sampling, clock division, power modes and scratch memory select.
//
// Overview of operation
// - Address latch strobe repeats every six clocks.
// - Internal clock enables run at half rate.
// - Reset pin sampled once per machine cycle.
// - Reset pin glitches filtered before sampling.
// - Reset presets ports to ones, stack to seven.
// - Reset clears registers, power bit 4 kept.
// - Idle request gates processor clock only.
// - Interrupt or reset ends idle.
// - Power-down stops all clocks and oscillator.
// - Power-down ends on reset or level interrupt.
// - Scratch memory off after reset, bit 4 enables.
// - Pointer moves use scratch memory when enabled.
// - Moves above 0xFF still go external.
// - Scratch accesses hold bus ports only during internal execution.
// - Control at BFh, unlock at F6h.
`timescale 1ns/1ps

module rpac_ctrl
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Pins
    input wire logic rst_pin,
    input wire logic ext_irq_zero_pin_n,
    input wire logic ext_irq_one_pin_n,
    // Interrupt logic
    input wire logic irq_pending,
    input wire logic ex0_en,
    input wire logic ex1_en,
    input wire logic it0,
    input wire logic it1,
    // Special register bus
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    output logic [7:0] sfr_rdata_r,
    output logic sfr_hit_r,
    // External move requests
    input wire logic xm_req,
    input wire logic xm_we,
    input wire logic xm_ri,
    input wire logic xm_int_exec,
    input wire logic [15:0] xm_addr,
    input wire logic [7:0] xm_wdata,
    output logic [7:0] xm_rdata_r,
    output logic xm_done_r,
    output logic ext_rd_r,
    output logic ext_wr_r,
    output logic [15:0] ext_addr_r,
    output logic [7:0] ext_wdata_r,
    output logic port_hold_r,
    // Clocking and reset outputs
    output logic ale_r,
    output logic cpu_clk_en_r,
    output logic per_clk_en_r,
    output logic osc_run_r,
    output logic sys_rst_r
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] osc_cnt;
        logic ale;
        logic cpu_en;
        logic per_en;
        logic osc_run;
        logic rst_s1;
        logic rst_s2;
        logic [1:0] filt_cnt;
        logic rst_filt;
        logic [1:0] hits;
        logic sys_rst;
        logic ext_irq_zero_pin_s1;
        logic ext_irq_zero_pin_s2;
        logic ext_irq_one_pin_s1;
        logic ext_irq_one_pin_s2;
        logic [7:0] power_control_reg;
        logic [7:0] chp;
        logic [7:0] unl;
        rpac_pkg::rpac_unl_t ust;
        logic [7:0] rdata;
        logic hit;
        logic [255:0][7:0] mem;
        logic [7:0] xm_rdata;
        logic xm_done;
        logic ext_rd;
        logic ext_wr;
        logic [15:0] ext_addr;
        logic [7:0] ext_wdata;
        logic port_hold;
    } rpac_state_t;

    rpac_state_t s_r;
    rpac_state_t s_nxt;
    logic samp;
    logic lvl_wake;
    logic aux_hit;

    assign samp = s_r.osc_run && (s_r.osc_cnt == rpac_pkg::S5P2_CNT);
    assign lvl_wake = (ex0_en && !it0 && !s_r.ext_irq_zero_pin_s2)
        || (ex1_en && !it1 && !s_r.ext_irq_one_pin_s2);
    assign aux_hit = s_r.chp[rpac_pkg::AUX_ENABLE_BIT]
        && (xm_ri || (xm_addr[15:8] == 8'h00));

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;

        // Twelve clocks make six states of two phases each.
        if (s_r.osc_run)
        begin
            s_nxt.osc_cnt = (s_r.osc_cnt == rpac_pkg::OSC_LAST) ?
                4'h0 : s_r.osc_cnt + 4'h1;
        end
        s_nxt.ale = s_r.osc_run && ((s_r.osc_cnt == 4'h0)
            || (s_r.osc_cnt == 4'h1) || (s_r.osc_cnt == 4'h6)
            || (s_r.osc_cnt == 4'h7));
        // Enables on every second clock, so duty cycle has no effect.
        s_nxt.per_en = s_r.osc_run && s_r.osc_cnt[0];
        s_nxt.cpu_en = s_r.osc_run && s_r.osc_cnt[0]
            && !s_r.power_control_reg[rpac_pkg::IDLE_REQUEST_BIT];
        s_nxt.osc_run =
            !s_r.power_control_reg[rpac_pkg::POWERDOWN_REQUEST_BIT];

        // Pin synchronisers.
        s_nxt.rst_s1 = rst_pin;
        s_nxt.rst_s2 = s_r.rst_s1;
        s_nxt.ext_irq_zero_pin_s1 = ext_irq_zero_pin_n;
        s_nxt.ext_irq_zero_pin_s2 = s_r.ext_irq_zero_pin_s1;
        s_nxt.ext_irq_one_pin_s1 = ext_irq_one_pin_n;
        s_nxt.ext_irq_one_pin_s2 = s_r.ext_irq_one_pin_s1;

        // A level must hold for several clocks before it is believed,
        // on both edges, which also cleans up slow RC ramps.
        if (s_r.rst_s2 != s_r.rst_filt)
        begin
            if (s_r.filt_cnt == rpac_pkg::GLITCH_CYC - 2'h1)
            begin
                s_nxt.rst_filt = s_r.rst_s2;
                s_nxt.filt_cnt = 2'h0;
            end
            else
            begin
                s_nxt.filt_cnt = s_r.filt_cnt + 2'h1;
            end
        end
        else
        begin
            s_nxt.filt_cnt = 2'h0;
        end

        // One sample per machine cycle; two high samples in a row
        // are needed before the reset is applied.
        if (samp)
        begin
            if (s_r.rst_filt)
            begin
                if (s_r.hits != rpac_pkg::RST_MIN_MC)
                begin
                    s_nxt.hits = s_r.hits + 2'h1;
                end
                if (s_r.hits >= rpac_pkg::RST_MIN_MC - 2'h1)
                begin
                    s_nxt.sys_rst = 1'b1;
                end
            end
            else
            begin
                s_nxt.hits = 2'h0;
                s_nxt.sys_rst = 1'b0;
            end
        end

        // Register writes.
        if (sfr_we)
        begin
            case (sfr_addr)
                rpac_pkg::PWR_CTRL_ADDR:
                begin
                    s_nxt.power_control_reg = sfr_wdata;
                end
                rpac_pkg::CHIP_CTRL_ADDR:
                begin
                    if (s_r.ust == rpac_pkg::UL_OPEN)
                    begin
                        s_nxt.chp = sfr_wdata;
                    end
                end
                rpac_pkg::CHIP_UNLOCK_ADDR:
                begin
                    s_nxt.unl = sfr_wdata;
                    case (s_r.ust)
                        rpac_pkg::UL_LOCKED:
                        begin
                            if (sfr_wdata == rpac_pkg::UNLOCK_KEY_FIRST)
                            begin
                                s_nxt.ust = rpac_pkg::UL_KEY1;
                            end
                        end
                        rpac_pkg::UL_KEY1:
                        begin
                            if (sfr_wdata == rpac_pkg::UNLOCK_KEY_SECOND)
                            begin
                                s_nxt.ust = rpac_pkg::UL_OPEN;
                            end
                            else if (sfr_wdata
                                != rpac_pkg::UNLOCK_KEY_FIRST)
                            begin
                                s_nxt.ust = rpac_pkg::UL_LOCKED;
                            end
                        end
                        rpac_pkg::UL_OPEN:
                        begin
                            if (sfr_wdata == rpac_pkg::UNLOCK_RELOCK)
                            begin
                                s_nxt.ust = rpac_pkg::UL_LOCKED;
                            end
                        end
                        default:
                        begin
                            s_nxt.ust = rpac_pkg::UL_LOCKED;
                        end
                    endcase
                end
                default:
                begin
                end
            endcase
        end

        // Wake-up clears the request bit; it wins over a write in the
        // same cycle so that a wake is never lost.
        if (s_r.power_control_reg[rpac_pkg::IDLE_REQUEST_BIT]
            && (irq_pending || s_r.sys_rst))
        begin
            s_nxt.power_control_reg[rpac_pkg::IDLE_REQUEST_BIT] = 1'b0;
        end
        if (s_r.power_control_reg[rpac_pkg::POWERDOWN_REQUEST_BIT]
            && (lvl_wake || s_r.rst_filt))
        begin
            // The oscillator is stopped, so the filtered pin wakes the
            // part directly and the sampler then applies the reset.
            s_nxt.power_control_reg[rpac_pkg::POWERDOWN_REQUEST_BIT] =
                1'b0;
        end

        // Register reads.
        s_nxt.hit = 1'b1;
        case (sfr_addr)
            rpac_pkg::PWR_CTRL_ADDR: s_nxt.rdata = s_r.power_control_reg;
            rpac_pkg::CHIP_CTRL_ADDR: s_nxt.rdata = s_r.chp;
            rpac_pkg::CHIP_UNLOCK_ADDR: s_nxt.rdata = s_r.unl;
            default:
            begin
                s_nxt.rdata = 8'h00;
                s_nxt.hit = 1'b0;
            end
        endcase

        // External moves.
        s_nxt.xm_done = 1'b0;
        s_nxt.ext_rd = 1'b0;
        s_nxt.ext_wr = 1'b0;
        s_nxt.port_hold = 1'b0;
        if (xm_req && !s_r.sys_rst)
        begin
            if (aux_hit)
            begin
                if (xm_we)
                begin
                    s_nxt.mem[xm_addr[7:0]] = xm_wdata;
                end
                s_nxt.xm_rdata = s_r.mem[xm_addr[7:0]];
                s_nxt.xm_done = 1'b1;
                s_nxt.port_hold = xm_int_exec;
            end
            else
            begin
                s_nxt.ext_rd = !xm_we;
                s_nxt.ext_wr = xm_we;
                s_nxt.ext_addr = xm_addr;
                s_nxt.ext_wdata = xm_wdata;
            end
        end

        // Reset clears the power, control and unlock registers, all but power bit 4.
        if (s_r.sys_rst)
        begin
            s_nxt.power_control_reg = rpac_pkg::SFR_CLEAR_VAL;
            s_nxt.power_control_reg[rpac_pkg::PWR_KEEP_BIT] =
                s_r.power_control_reg[rpac_pkg::PWR_KEEP_BIT];
            s_nxt.chp = rpac_pkg::SFR_CLEAR_VAL;
            s_nxt.unl = rpac_pkg::SFR_CLEAR_VAL;
            s_nxt.ust = rpac_pkg::UL_LOCKED;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s_r <= '0;
            s_r.power_control_reg <= rpac_pkg::PWR_CTRL_POR;
            s_r.osc_run <= 1'b1;
            // The interrupt pins idle high; starting the synchronisers
            // low would fake a level request right after reset.
            s_r.ext_irq_zero_pin_s1 <= 1'b1;
            s_r.ext_irq_zero_pin_s2 <= 1'b1;
            s_r.ext_irq_one_pin_s1 <= 1'b1;
            s_r.ext_irq_one_pin_s2 <= 1'b1;
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    // Port latches load PORT_LATCH_RST and the stack STACK_POINTER_RST
    // while sys_rst_r is high.
    assign sys_rst_r = s_r.sys_rst;
    assign ale_r = s_r.ale;
    assign cpu_clk_en_r = s_r.cpu_en;
    assign per_clk_en_r = s_r.per_en;
    assign osc_run_r = s_r.osc_run;
    assign sfr_rdata_r = s_r.rdata;
    assign sfr_hit_r = s_r.hit;
    assign xm_rdata_r = s_r.xm_rdata;
    assign xm_done_r = s_r.xm_done;
    assign ext_rd_r = s_r.ext_rd;
    assign ext_wr_r = s_r.ext_wr;
    assign ext_addr_r = s_r.ext_addr;
    assign ext_wdata_r = s_r.ext_wdata;
    assign port_hold_r = s_r.port_hold;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn || !ce);

    a_ale_period: assert property (
        $rose(ale_r) && osc_run_r |-> ##6 ($rose(ale_r) || !osc_run_r))
        else $error("strobe period is not six clocks");
    a_div_two: assert property (
        per_clk_en_r |=> !per_clk_en_r)
        else $error("clock enable faster than half rate");
    a_sample_phase: assert property (
        $rose(sys_rst_r) |-> $past(s_r.osc_cnt) == rpac_pkg::S5P2_CNT)
        else $error("reset not taken at sample phase");
    a_rst_two_mc: assert property (
        $rose(sys_rst_r) |-> $past(s_r.hits) == 2'h1)
        else $error("reset taken before two samples");
    a_glitch_filter: assert property (
        $rose(s_r.rst_filt) |-> $past(s_r.rst_s2)
            && $past(s_r.rst_s2, 3))
        else $error("short reset pulse passed filter");
    a_rst_clear: assert property (
        sys_rst_r |=> s_r.chp == rpac_pkg::SFR_CLEAR_VAL
            && s_r.power_control_reg[1:0] == 2'b00
            && $stable(s_r.power_control_reg[rpac_pkg::PWR_KEEP_BIT]))
        else $error("reset did not clear registers");
    a_idle_gate: assert property (
        s_r.power_control_reg[rpac_pkg::IDLE_REQUEST_BIT] && osc_run_r
            |=> !cpu_clk_en_r)
        else $error("processor clock runs in idle");
    a_idle_wake: assert property (
        s_r.power_control_reg[rpac_pkg::IDLE_REQUEST_BIT] && irq_pending
            |=> !s_r.power_control_reg[rpac_pkg::IDLE_REQUEST_BIT])
        else $error("idle not left on interrupt");
    a_pd_stop: assert property (
        s_r.power_control_reg[rpac_pkg::POWERDOWN_REQUEST_BIT]
            |=> !osc_run_r ##1 !per_clk_en_r && !cpu_clk_en_r)
        else $error("clocks run in power-down");
    a_pd_wake: assert property (
        s_r.power_control_reg[rpac_pkg::POWERDOWN_REQUEST_BIT] && lvl_wake
            |=> !s_r.power_control_reg[rpac_pkg::POWERDOWN_REQUEST_BIT])
        else $error("power-down not left on level interrupt");
    a_unlock_gate: assert property (
        sfr_we && sfr_addr == rpac_pkg::CHIP_CTRL_ADDR
            && s_r.ust != rpac_pkg::UL_OPEN && !s_r.sys_rst
            |=> $stable(s_r.chp))
        else $error("locked control register changed");
    a_aux_route: assert property (
        xm_req && aux_hit && !s_r.sys_rst
            |=> xm_done_r && !ext_rd_r && !ext_wr_r)
        else $error("scratch access reached the bus");
    a_ext_high: assert property (
        xm_req && !xm_ri && xm_addr[15:8] != 8'h00 && !s_r.sys_rst
            |=> (ext_rd_r || ext_wr_r) && !xm_done_r)
        else $error("high move not sent to bus");

    c_idle_wake: cover property (
        s_r.power_control_reg[rpac_pkg::IDLE_REQUEST_BIT] ##1 irq_pending);
    c_pd_wake: cover property (
        s_r.power_control_reg[rpac_pkg::POWERDOWN_REQUEST_BIT] && lvl_wake);
    c_reset: cover property ($rose(sys_rst_r));
    c_aux_write: cover property (xm_req && xm_we && aux_hit);

endmodule

// [testbench/rpac_far_side.sv]
// Model of the external reset circuit, interrupt logic and interrupt pins.
`timescale 1ns/1ps

module rpac_far_side
(
    // Clock
    input wire logic clk,
    // Lines into the block
    output logic rst_pin,
    output logic irq_pending,
    output logic [1:0] irq_pin_n
);
    // ----------
    // Reset circuit
    // ----------
    localparam int MC_CLKS = 12;

    initial
    begin
        rst_pin = 1'b0;
        irq_pending = 1'b0;
        irq_pin_n = 2'b11;
    end

    // A shorter request is stretched, so a reset always lands.
    task automatic hold_reset(input int n);
        int len;
        len = (n < 2 * MC_CLKS) ? 2 * MC_CLKS : n;
        @(posedge clk) #1;
        rst_pin = 1'b1;
        repeat (len) @(posedge clk);
        #1;
        rst_pin = 1'b0;
    endtask

    // Deliberately too short: the block has to ignore it.
    task automatic glitch(input int n);
        @(posedge clk) #1;
        rst_pin = 1'b1;
        repeat (n) @(posedge clk);
        #1;
        rst_pin = 1'b0;
    endtask

    // ----------
    // Interrupt side
    // ----------
    task automatic irq(input int n);
        @(posedge clk) #1;
        irq_pending = 1'b1;
        repeat (n) @(posedge clk);
        #1;
        irq_pending = 1'b0;
    endtask

    task automatic pin(input int k, input logic v);
        @(posedge clk) #1;
        irq_pin_n[k] = v;
    endtask
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the reset, power and scratch memory control.
`timescale 1ns/1ps

module testbench;
    // ----------
    // Signals and instances
    // ----------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic ex0_en = 1'b0;
    logic ex1_en = 1'b0;
    logic it0 = 1'b1;
    logic it1 = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_we = 1'b0;
    logic xm_req = 1'b0;
    logic xm_we = 1'b0;
    logic xm_ri = 1'b0;
    logic xm_int_exec = 1'b0;
    logic [15:0] xm_addr = 16'h0000;
    logic [7:0] xm_wdata = 8'h00;
    logic rst_pin, irq_pending;
    logic [1:0] irq_pin_n;
    logic [7:0] sfr_rdata_r, xm_rdata_r, ext_wdata_r;
    logic sfr_hit_r, xm_done_r, ext_rd_r, ext_wr_r, port_hold_r;
    logic [15:0] ext_addr_r;
    logic ale_r, cpu_clk_en_r, per_clk_en_r, osc_run_r, sys_rst_r;
    int n_fail = 0;
    int n_tests = 0;

    always #20 clk = ~clk;

    rpac_far_side rpac_far_side_inst
    (
        .clk(clk), .rst_pin(rst_pin), .irq_pending(irq_pending),
        .irq_pin_n(irq_pin_n)
    );

    rpac_ctrl rpac_ctrl_inst
    (
        .clk(clk), .resetn(resetn), .ce(ce), .rst_pin(rst_pin),
        .ext_irq_zero_pin_n(irq_pin_n[0]), .ext_irq_one_pin_n(irq_pin_n[1]),
        .irq_pending(irq_pending), .ex0_en(ex0_en), .ex1_en(ex1_en),
        .it0(it0), .it1(it1), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_we(sfr_we), .sfr_rdata_r(sfr_rdata_r), .sfr_hit_r(sfr_hit_r),
        .xm_req(xm_req), .xm_we(xm_we), .xm_ri(xm_ri),
        .xm_int_exec(xm_int_exec), .xm_addr(xm_addr), .xm_wdata(xm_wdata),
        .xm_rdata_r(xm_rdata_r), .xm_done_r(xm_done_r),
        .ext_rd_r(ext_rd_r), .ext_wr_r(ext_wr_r), .ext_addr_r(ext_addr_r),
        .ext_wdata_r(ext_wdata_r), .port_hold_r(port_hold_r),
        .ale_r(ale_r), .cpu_clk_en_r(cpu_clk_en_r),
        .per_clk_en_r(per_clk_en_r), .osc_run_r(osc_run_r),
        .sys_rst_r(sys_rst_r)
    );

    // ----------
    // Shared tasks
    // ----------
    task automatic chk(input string w, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", w, e, g);
        end
    endtask

    // Leaves the bench one step after an edge, where outputs have settled.
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sfr_we = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        step(1);
        sfr_we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input logic hit);
        @(posedge clk) #1;
        sfr_addr = a;
        step(1);
        chk("read data", 16'(e), 16'(sfr_rdata_r));
        chk("register hit", 16'(hit), 16'(sfr_hit_r));
    endtask

    task automatic xm(input logic we, ri, ie, input logic [15:0] a,
        input logic [7:0] d);
        @(posedge clk) #1;
        {xm_req, xm_we, xm_ri, xm_int_exec} = {1'b1, we, ri, ie};
        xm_addr = a;
        xm_wdata = d;
        step(1);
        xm_req = 1'b0;
    endtask

    task automatic cnt(input int n, output int a, c, p);
        logic ale_d;
        a = 0;
        c = 0;
        p = 0;
        ale_d = ale_r;
        repeat (n)
        begin
            step(1);
            a += int'(ale_r && !ale_d);
            c += int'(cpu_clk_en_r);
            p += int'(per_clk_en_r);
            ale_d = ale_r;
        end
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_clock();
        int a, c, p;
        cnt(60, a, c, p);
        chk("ale pulses", 16'h000a, 16'(a));
        chk("core enables", 16'h001e, 16'(c));
        chk("peripheral enables", 16'h001e, 16'(p));
        // A low clock enable must freeze the strobe generator.
        ce = 1'b0;
        cnt(12, a, c, p);
        chk("frozen ale pulses", 16'h0000, 16'(a));
        ce = 1'b1;
        rd(8'h87, 8'h30, 1'b1);
        rd(8'h80, 8'h00, 1'b0);
        $display("test clock done");
    endtask

    task automatic t_unlock();
        wr(8'hbf, 8'h10);
        rd(8'hbf, 8'h00, 1'b1);
        wr(8'hf6, 8'h87);
        wr(8'hf6, 8'h59);
        wr(8'hbf, 8'h10);
        wr(8'hf6, 8'h00);
        rd(8'hbf, 8'h10, 1'b1);
        wr(8'hbf, 8'h00);
        rd(8'hbf, 8'h10, 1'b1);
        rd(8'hf6, 8'h00, 1'b1);
        // A wrong second key relocks, so a later 59h opens nothing.
        wr(8'hf6, 8'h87);
        wr(8'hf6, 8'h12);
        wr(8'hf6, 8'h59);
        wr(8'hbf, 8'h00);
        rd(8'hbf, 8'h10, 1'b1);
        $display("test unlock done");
    endtask

    task automatic t_aux();
        xm(1'b1, 1'b1, 1'b1, 16'h0012, 8'h34);
        chk("scratch done", 16'h0001, 16'(xm_done_r));
        chk("ports held", 16'h0001, 16'(port_hold_r));
        chk("external write", 16'h0000, 16'(ext_wr_r));
        xm(1'b0, 1'b1, 1'b0, 16'h0012, 8'h00);
        chk("scratch data", 16'h0034, 16'(xm_rdata_r));
        chk("ports held", 16'h0000, 16'(port_hold_r));
        xm(1'b0, 1'b0, 1'b0, 16'h0012, 8'h00);
        chk("scratch done", 16'h0001, 16'(xm_done_r));
        chk("scratch data", 16'h0034, 16'(xm_rdata_r));
        xm(1'b1, 1'b0, 1'b0, 16'h1234, 8'h56);
        chk("external write", 16'h0001, 16'(ext_wr_r));
        chk("scratch done", 16'h0000, 16'(xm_done_r));
        chk("external address", 16'h1234, ext_addr_r);
        chk("external data", 16'h0056, 16'(ext_wdata_r));
        xm(1'b0, 1'b0, 1'b0, 16'h0100, 8'h00);
        chk("external read", 16'h0001, 16'(ext_rd_r));
        $display("test scratch done");
    endtask

    task automatic t_idle();
        int a, c, p;
        wr(8'h87, 8'h31);
        step(2);
        cnt(12, a, c, p);
        chk("core enables", 16'h0000, 16'(c));
        chk("peripheral enables", 16'h0006, 16'(p));
        rpac_far_side_inst.irq(2);
        step(4);
        cnt(12, a, c, p);
        chk("core enables", 16'h0006, 16'(c));
        rd(8'h87, 8'h30, 1'b1);
        $display("test idle done");
    endtask

    // Edge-triggered pins must not wake the part; level-triggered ones do.
    task automatic t_pd();
        int a, c, p;
        for (int k = 0; k < 2; k++)
        begin
            {ex0_en, ex1_en, it0, it1} = 4'b1111;
            wr(8'h87, 8'h32);
            step(3);
            chk("oscillator", 16'h0000, 16'(osc_run_r));
            cnt(12, a, c, p);
            chk("all enables", 16'h0000, 16'(a + c + p));
            rpac_far_side_inst.pin(k, 1'b0);
            step(8);
            chk("oscillator", 16'h0000, 16'(osc_run_r));
            rpac_far_side_inst.pin(k, 1'b1);
            step(4);
            {it0, it1} = 2'b00;
            rpac_far_side_inst.pin(k, 1'b0);
            step(8);
            chk("oscillator", 16'h0001, 16'(osc_run_r));
            rpac_far_side_inst.pin(k, 1'b1);
            rd(8'h87, 8'h30, 1'b1);
        end
        $display("test power-down done");
    endtask

    task automatic t_reset();
        int a, c, p;
        rpac_far_side_inst.glitch(2);
        step(30);
        chk("system reset", 16'h0000, 16'(sys_rst_r));
        wr(8'h87, 8'h31);
        rpac_far_side_inst.hold_reset(36);
        chk("system reset", 16'h0001, 16'(sys_rst_r));
        for (int i = 0; i < 40 && sys_rst_r !== 1'b0; i++)
            step(1);
        chk("system reset", 16'h0000, 16'(sys_rst_r));
        rd(8'h87, 8'h10, 1'b1);
        rd(8'hbf, 8'h00, 1'b1);
        cnt(12, a, c, p);
        chk("core enables", 16'h0006, 16'(c));
        xm(1'b1, 1'b1, 1'b0, 16'h0012, 8'h34);
        chk("external write", 16'h0001, 16'(ext_wr_r));
        $display("test reset done");
    endtask

    // ----------
    // Sequence and verdict
    // ----------
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_clock();
        t_unlock();
        t_aux();
        t_idle();
        t_pd();
        t_reset();
        end_of_test();
    end

    // The scenarios need well under a thousand cycles.
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule
